// ### rtl/mcd_pkg.sv
package mcd_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_NS = 20;
	// Constant-level detect: least time, rounded up to whole cycles
	localparam int STUCK_NS = 2000000;
	localparam int STUCK_CYC = (STUCK_NS + CLK_NS - 1) / CLK_NS;
	// Trajectory update period: longest time, rounded down
	localparam int TRAJ_NS = 1000;
	localparam logic [7:0] TRAJ_CYC = 8'(TRAJ_NS / CLK_NS);

	// ****************************************
	// Widths and fixed-point layout
	// ****************************************
	localparam int CNT_W = 16;
	localparam int FRAC = 12;
	localparam int DUTY_W = FRAC + 1;
	localparam logic [DUTY_W-1:0] DUTY_FULL = 13'h1000;
	localparam logic [DUTY_W-1:0] DUTY_HALF = 13'h0800;
	localparam int CMD_W = 16;
	localparam int POS_W = 32;
	localparam logic [15:0] CMD_LIM = 16'h7FFF;

	// ****************************************
	// Modes and formats
	// ****************************************
	typedef enum logic [1:0] {MCD_MODE_CUR, MCD_MODE_VEL, MCD_MODE_POS, MCD_MODE_OFF} mcd_mode_t;
	typedef enum logic {MCD_PWM_ONE, MCD_PWM_TWO} mcd_pwm_fmt_t;
	typedef enum logic [1:0] {MCD_STEP_DIR, MCD_STEP_UPDN, MCD_STEP_QUAD} mcd_step_fmt_t;

endpackage

// ### rtl/mcd_duty_if.sv
`timescale 1ns/1ps
`default_nettype none

// Measured duty of the PWM pin, held until the next period completes or a constant level forces 0 or full duty
interface mcd_duty_if;
	logic [mcd_pkg::DUTY_W-1:0] duty;
	logic                       valid;
	logic                       stuck_lo;
	logic                       stuck_hi;
	modport src (output duty, output valid, output stuck_lo, output stuck_hi);
	modport snk (input duty, input valid, input stuck_lo, input stuck_hi);
endinterface

`default_nettype wire

// ### rtl/mcd_duty_meter.sv
`timescale 1ns/1ps
`default_nettype none

module mcd_duty_meter #(
	parameter int STUCK_CYC = mcd_pkg::STUCK_CYC
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic resetn_in,
	// Synchronised PWM level
	input  wire logic pwm_in,
	// Measurement result
	mcd_duty_if.src   duty_if
);
	localparam int CW = mcd_pkg::CNT_W;
	localparam int NW = mcd_pkg::CNT_W + mcd_pkg::FRAC;
	localparam int IW = $clog2(STUCK_CYC + 1);

	logic          pwm_d;
	logic [CW-1:0] per_cnt;
	logic [CW-1:0] hi_cnt;
	logic [CW-1:0] den;
	logic [NW-1:0] num;
	logic [NW-1:0] quo;
	logic [CW:0]   rem;
	logic [5:0]    bits;
	logic          busy;
	logic          armed;
	logic [IW-1:0] idle;

	// ****************************************
	// Edge, divider step and limit decode
	// ****************************************
	wire logic                       rise     = pwm_in & ~pwm_d;
	wire logic                       edge_any = pwm_in ^ pwm_d;
	wire logic                       per_max  = &per_cnt;
	wire logic                       idle_max = (idle == IW'(STUCK_CYC));
	wire logic [CW:0]                rem_sh   = {rem[CW-1:0], num[NW-1]};
	wire logic                       rem_ge   = (rem_sh >= {1'b0, den});
	wire logic [CW:0]                rem_sub  = rem_sh - {1'b0, den};
	wire logic [NW-1:0]              full_ext = NW'(mcd_pkg::DUTY_FULL);
	wire logic [mcd_pkg::DUTY_W-1:0] quo_sat  = (quo > full_ext) ? mcd_pkg::DUTY_FULL
	                                                             : quo[mcd_pkg::DUTY_W-1:0];

	// Period and high-time counters; an overlong period is discarded, not wrapped
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			pwm_d <= 1'b0;
			per_cnt <= '0;
			hi_cnt <= '0;
			armed <= 1'b0;
			idle <= '0;
		end else begin
			pwm_d <= pwm_in;
			idle <= edge_any ? '0 : (idle_max ? idle : idle + 1'b1);
			if (rise) begin
				per_cnt <= CW'(1);
				hi_cnt <= CW'(1);
				armed <= 1'b1;
			end else if (!per_max) begin
				per_cnt <= per_cnt + 1'b1;
				hi_cnt <= hi_cnt + CW'(pwm_in);
			end else begin
				armed <= 1'b0;
			end
		end
	end

	// Serial divide high/period; constant level forces 0 or full duty
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			busy <= 1'b0;
			bits <= '0;
			num <= '0;
			den <= '0;
			quo <= '0;
			rem <= '0;
			duty_if.duty <= '0;
			duty_if.valid <= 1'b0;
			duty_if.stuck_lo <= 1'b0;
			duty_if.stuck_hi <= 1'b0;
		end else begin
			duty_if.valid <= 1'b0;
			duty_if.stuck_lo <= idle_max & ~pwm_d;
			duty_if.stuck_hi <= idle_max & pwm_d;
			if (rise && armed && !busy) begin
				num <= {hi_cnt, mcd_pkg::FRAC'(0)};
				den <= per_cnt;
				rem <= '0;
				quo <= '0;
				bits <= 6'(NW);
				busy <= 1'b1;
			end else if (busy && bits != 6'h00) begin
				rem <= rem_ge ? rem_sub : rem_sh;
				quo <= {quo[NW-2:0], rem_ge};
				num <= num << 1;
				bits <= bits - 1'b1;
			end else if (busy) begin
				busy <= 1'b0;
				duty_if.duty <= quo_sat;
				duty_if.valid <= 1'b1;
			end else if (idle_max) begin
				duty_if.duty <= pwm_d ? mcd_pkg::DUTY_FULL : '0;
			end
		end
	end

endmodule

`default_nettype wire

// ### rtl/mcd_cmd_decoder.sv
// Functional notes
// - PWM input: one-wire or two-wire format.
// - One-wire: half duty zero, signed either side.
// - PWM drives current or velocity command.
// - Two-wire: duty magnitude, polarity pin sign.
// - Two-wire: 0% zero, 100% maximum, linear.
// - Option inverts two-wire duty mapping.
// - Protection turns 0%/100% duty into zero.
// - Position inputs: step/dir, up/down, quadrature.
// - Invert bit reverses decoded position sign.
// - Step pulse moves one step, direction signs.
// - Rising or falling step edge selectable.
// - Programmable position change per step.
// - Up pulses add, down pulses subtract.
// - Quadrature phase gives speed and direction.
// - Quadrature count scale programmable.
// - Trajectory limits acceleration in position mode.
// - Zero acceleration limit bypasses trajectory.
`timescale 1ns/1ps
`default_nettype none

module mcd_cmd_decoder #(
	parameter int STUCK_CYC = mcd_pkg::STUCK_CYC
) (
	// Clock and reset
	input  wire logic                           mclk_in,
	input  wire logic                           resetn_in,
	// Command pins from the motion controller
	input  wire logic                           cmd_a_in,
	input  wire logic                           cmd_b_in,
	// Mode and PWM configuration
	input  wire mcd_pkg::mcd_mode_t             mode_in,
	input  wire mcd_pkg::mcd_pwm_fmt_t          pwm_fmt_in,
	input  wire logic                           pwm_invert_in,
	input  wire logic                           pwm_protect_in,
	input  wire logic [15:0]                    pwm_scale_in,
	// Position input configuration
	input  wire mcd_pkg::mcd_step_fmt_t         step_fmt_in,
	input  wire logic                           step_invert_in,
	input  wire logic                           step_fall_edge_in,
	input  wire logic signed [15:0]             gear_in,
	input  wire logic [15:0]                    max_accel_in,
	input  wire logic [15:0]                    max_vel_in,
	// Decoded commands and status
	output var  logic signed [mcd_pkg::CMD_W-1:0] cur_cmd_out,
	output var  logic signed [mcd_pkg::CMD_W-1:0] vel_cmd_out,
	output var  logic signed [mcd_pkg::POS_W-1:0] pos_cmd_out,
	output var  logic signed [mcd_pkg::POS_W-1:0] pos_target_out,
	output var  logic                           pwm_stuck_out
);
	localparam int PW = mcd_pkg::DUTY_W + 2;

	// Saturate a signed value to plus or minus an unsigned limit
	function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
	                                             input logic [15:0] lim);
		logic signed [31:0] l;
		l = $signed({16'h0000, lim});
		if (v > l) begin
			return l;
		end else if (v < -l) begin
			return -l;
		end
		return v;
	endfunction

	// Quadrature step from {a_old, b_old, a_new, b_new}
	function automatic logic signed [1:0] quad_dir(input logic [3:0] ab);
		case (ab)
			4'h2, 4'hB, 4'hD, 4'h4: return 2'sb01;
			4'h1, 4'h7, 4'hE, 4'h8: return 2'sb11;
			default: return 2'sb00;
		endcase
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic a_s1;
	logic a_s2;
	logic a_s3;
	logic b_s1;
	logic b_s2;
	logic b_s3;

	// Stage 1 feeds only stage 2; stage 3 is the edge-detect history
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			{a_s1, a_s2, a_s3} <= 3'h0;
			{b_s1, b_s2, b_s3} <= 3'h0;
		end else begin
			{a_s1, a_s2, a_s3} <= {cmd_a_in, a_s1, a_s2};
			{b_s1, b_s2, b_s3} <= {cmd_b_in, b_s1, b_s2};
		end
	end

	// ****************************************
	// PWM duty decode
	// ****************************************
	mcd_duty_if duty_if ();

	mcd_duty_meter #(
		.STUCK_CYC (STUCK_CYC)
	) u_meter (
		.clk_in    (mclk_in),
		.resetn_in (resetn_in),
		.pwm_in    (a_s2),
		.duty_if   (duty_if.src)
	);

	// One-wire is centred on half duty; two-wire takes sign from the polarity pin
	wire logic [mcd_pkg::DUTY_W-1:0] duty     = duty_if.duty;
	wire logic signed [PW-1:0]       one_raw  = $signed({2'b00, duty})
	                                            - $signed({2'b00, mcd_pkg::DUTY_HALF});
	wire logic signed [PW-1:0]       one_v    = one_raw <<< 1;
	wire logic [mcd_pkg::DUTY_W-1:0] two_mag  = pwm_invert_in ? mcd_pkg::DUTY_FULL - duty : duty;
	wire logic signed [PW-1:0]       two_pos  = $signed({2'b00, two_mag});
	wire logic signed [PW-1:0]       two_v    = b_s2 ? two_pos : -two_pos;
	wire logic signed [PW-1:0]       one_sel  = pwm_invert_in ? -one_v : one_v;
	wire logic                       at_limit = duty_if.stuck_lo | duty_if.stuck_hi
	                                            | duty == '0 | duty == mcd_pkg::DUTY_FULL;
	wire logic                       force_z  = pwm_protect_in & at_limit;
	wire logic signed [PW-1:0]       pwm_val  = force_z ? '0
	                                            : (pwm_fmt_in == mcd_pkg::MCD_PWM_TWO) ? two_v
	                                            : one_sel;
	// Both factors widened first so the product is formed at full width
	wire logic signed [31:0]         pwm_prod = 32'(pwm_val) * 32'($signed({1'b0, pwm_scale_in}));
	wire logic signed [31:0]         pwm_sat  = clamp(pwm_prod >>> mcd_pkg::FRAC,
	                                                  mcd_pkg::CMD_LIM);
	wire logic                       is_cur   = (mode_in == mcd_pkg::MCD_MODE_CUR);
	wire logic                       is_vel   = (mode_in == mcd_pkg::MCD_MODE_VEL);

	// Route the scaled PWM value to the loop the mode selects
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			cur_cmd_out <= '0;
			vel_cmd_out <= '0;
			pwm_stuck_out <= 1'b0;
		end else begin
			cur_cmd_out <= is_cur ? pwm_sat[mcd_pkg::CMD_W-1:0] : '0;
			vel_cmd_out <= is_vel ? pwm_sat[mcd_pkg::CMD_W-1:0] : '0;
			pwm_stuck_out <= duty_if.stuck_lo | duty_if.stuck_hi;
		end
	end

	// ****************************************
	// Position step decode
	// ****************************************
	// Direction is sampled on the active step edge, after synchronising
	wire logic              a_act    = step_fall_edge_in ? (a_s3 & ~a_s2) : (a_s2 & ~a_s3);
	wire logic              b_act    = step_fall_edge_in ? (b_s3 & ~b_s2) : (b_s2 & ~b_s3);
	wire logic signed [1:0] dir_sgn  = a_act ? (b_s2 ? 2'sb01 : 2'sb11) : 2'sb00;
	wire logic signed [1:0] updn_sgn = (a_act == b_act) ? 2'sb00
	                                   : (a_act ? 2'sb01 : 2'sb11);
	wire logic signed [1:0] quad_sgn = quad_dir({a_s3, b_s3, a_s2, b_s2});
	wire logic signed [1:0] raw_sgn  = (step_fmt_in == mcd_pkg::MCD_STEP_DIR)  ? dir_sgn
	                                   : (step_fmt_in == mcd_pkg::MCD_STEP_UPDN) ? updn_sgn
	                                   : (step_fmt_in == mcd_pkg::MCD_STEP_QUAD) ? quad_sgn
	                                   : 2'sb00;
	wire logic signed [1:0] step_sgn = step_invert_in ? -raw_sgn : raw_sgn;
	wire logic signed [31:0] gear_ext = 32'(gear_in);
	wire logic               is_pos   = (mode_in == mcd_pkg::MCD_MODE_POS);
	wire logic signed [31:0] step_delta = !is_pos ? 32'sh0
	                                      : (step_sgn == 2'sb01) ? gear_ext
	                                      : (step_sgn == 2'sb11) ? -gear_ext : 32'sh0;

	// Accumulate geared steps into the position target
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			pos_target_out <= '0;
		end else begin
			pos_target_out <= pos_target_out + step_delta;
		end
	end

	// ****************************************
	// Trajectory limiter
	// ****************************************
	logic [7:0]         tick_cnt;
	logic signed [31:0] vel;

	// Velocity tracks the position error under speed and acceleration caps.
	// No deceleration look-ahead: a large step may overshoot slightly.
	wire logic               tick     = (tick_cnt == mcd_pkg::TRAJ_CYC - 8'h01);
	wire logic               bypass   = (max_accel_in == 16'h0000);
	wire logic signed [31:0] want_vel = clamp(pos_target_out - pos_cmd_out, max_vel_in);
	wire logic signed [31:0] next_vel = vel + clamp(want_vel - vel, max_accel_in);

	// Tick divider and trajectory state
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			tick_cnt <= '0;
			vel <= '0;
			pos_cmd_out <= '0;
		end else begin
			tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
			if (bypass) begin
				vel <= '0;
				pos_cmd_out <= pos_target_out;
			end else if (tick) begin
				vel <= next_vel;
				pos_cmd_out <= pos_cmd_out + next_vel;
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking mcd_cb @(posedge mclk_in);
	endclocking
	default disable iff (!resetn_in);

	a_sync_two_stage: assert property ($past(resetn_in, 2) && $past(resetn_in)
		|-> a_s2 == $past(cmd_a_in, 2) && b_s2 == $past(cmd_b_in, 2))
		else $error("pin not delayed by two flops");
	a_one_wire_mid: assert property (pwm_fmt_in == mcd_pkg::MCD_PWM_ONE
		&& duty == mcd_pkg::DUTY_HALF |-> pwm_val == '0)
		else $error("half duty not zero");
	a_two_wire_ends: assert property (pwm_fmt_in == mcd_pkg::MCD_PWM_TWO && !pwm_invert_in
		&& !pwm_protect_in && b_s2 && duty == mcd_pkg::DUTY_FULL
		|-> pwm_val == $signed({2'b00, mcd_pkg::DUTY_FULL}))
		else $error("full duty not maximum");
	a_protect_zero: assert property (pwm_protect_in && is_vel
		&& (duty_if.stuck_lo || duty_if.stuck_hi) |=> vel_cmd_out == '0)
		else $error("stuck pwm not zeroed");
	a_mode_route: assert property (!is_cur |=> cur_cmd_out == '0)
		else $error("current command outside current mode");
	a_step_dir_sign: assert property (step_fmt_in == mcd_pkg::MCD_STEP_DIR && a_act
		&& !step_invert_in |-> step_sgn == (b_s2 ? 2'sb01 : 2'sb11))
		else $error("step sign wrong");
	a_updn_sign: assert property (step_fmt_in == mcd_pkg::MCD_STEP_UPDN && b_act && !a_act
		&& !step_invert_in |-> step_sgn == 2'sb11)
		else $error("down pulse not negative");
	a_target_gear: assert property (is_pos && step_sgn == 2'sb01
		|=> pos_target_out == $past(pos_target_out) + $past(gear_ext))
		else $error("geared step not applied");
	a_accel_limit: assert property (!bypass && tick |=> (vel - $past(vel))
		<= $signed({16'h0000, $past(max_accel_in)})
		&& ($past(vel) - vel) <= $signed({16'h0000, $past(max_accel_in)}))
		else $error("acceleration above limit");
	a_bypass_direct: assert property (bypass |=> pos_cmd_out == $past(pos_target_out))
		else $error("bypass not direct");

	// PWM format, sign, inversion, protection and velocity routing
	a_fmt_one_full: assert property (pwm_fmt_in == mcd_pkg::MCD_PWM_ONE && !force_z
		&& !pwm_invert_in && duty == mcd_pkg::DUTY_FULL
		|-> pwm_val == $signed({2'b00, mcd_pkg::DUTY_FULL}))
		else $error("one-wire full duty not maximum");
	a_two_wire_sign: assert property (pwm_fmt_in == mcd_pkg::MCD_PWM_TWO && !force_z
		|-> (b_s2 ? pwm_val >= 0 : pwm_val <= 0))
		else $error("polarity pin not obeyed");
	a_two_wire_inv: assert property (pwm_fmt_in == mcd_pkg::MCD_PWM_TWO && pwm_invert_in
		&& !force_z && b_s2 && duty == '0
		|-> pwm_val == $signed({2'b00, mcd_pkg::DUTY_FULL}))
		else $error("inverted zero duty not maximum");
	a_protect_now: assert property (force_z |-> pwm_val == '0)
		else $error("protected value not zero");
	a_vel_route: assert property (!is_vel |=> vel_cmd_out == '0)
		else $error("velocity command outside velocity mode");

	// Step decoding: formats, inversion, edges and gearing
	a_no_step_fmt: assert property (step_fmt_in == mcd_pkg::mcd_step_fmt_t'(2'h3)
		|-> step_sgn == 2'sb00)
		else $error("step in unused format");
	a_off_mode: assert property (!is_pos |=> pos_target_out == $past(pos_target_out))
		else $error("target moved outside position mode");
	a_step_invert: assert property (step_fmt_in == mcd_pkg::MCD_STEP_DIR && a_act
		&& step_invert_in |-> step_sgn == (b_s2 ? 2'sb11 : 2'sb01))
		else $error("inverted step sign wrong");
	a_edge_select: assert property (step_fmt_in == mcd_pkg::MCD_STEP_DIR
		&& !step_fall_edge_in && a_s3 && !a_s2 |-> dir_sgn == 2'sb00)
		else $error("falling edge counted in rising mode");
	a_updn_up: assert property (step_fmt_in == mcd_pkg::MCD_STEP_UPDN && a_act && !b_act
		&& !step_invert_in |-> step_sgn == 2'sb01)
		else $error("up pulse not positive");
	a_quad_skip: assert property (step_fmt_in == mcd_pkg::MCD_STEP_QUAD
		&& a_s2 != a_s3 && b_s2 != b_s3 |-> step_sgn == 2'sb00)
		else $error("skipped quadrature state counted");
	a_quad_gear: assert property (is_pos && step_fmt_in == mcd_pkg::MCD_STEP_QUAD
		&& step_sgn == 2'sb11
		|=> pos_target_out == $past(pos_target_out) - $past(gear_ext))
		else $error("quadrature count not geared");

	c_quad_step: cover property (step_fmt_in == mcd_pkg::MCD_STEP_QUAD && quad_sgn != 2'sb00);
	c_duty_done: cover property (duty_if.valid ##1 is_vel && vel_cmd_out != '0);
	c_traj_move: cover property (!bypass && tick && next_vel != 32'sh0);
	c_pwm_stuck: cover property (pwm_stuck_out);

endmodule

`default_nettype wire

// ### testbench/mcd_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// External motion controller model
// ****************************************
module mcd_ctl_model (
	// Clock
	input  wire logic clk_in,
	// Command pins
	output var  logic a_out,
	output var  logic b_out
);
	// Pins rest low until the first command
	initial begin
		a_out = 1'b0;
		b_out = 1'b0;
	end

	// Set both pins on the same falling clock edge and hold them seven clocks; B can move together with A
	task automatic drive(input logic a, input logic b);
		@(negedge clk_in);
		a_out = a;
		b_out = b;
		repeat (7) @(negedge clk_in);
	endtask

	// Fixed-frequency PWM on A, polarity as a static level on B
	task automatic pwm(input int high, input int period, input int n, input logic pol);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_in);
			a_out = 1'b1;
			b_out = pol;
			repeat (high) @(negedge clk_in);
			a_out = 1'b0;
			repeat (period - high - 1) @(negedge clk_in);
		end
	endtask
endmodule

`default_nettype wire

// ### testbench/tb_motion_command_input_decoder.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("wrong value %s exp %0d got %0d", n, e, g); end end

module tb_motion_command_input_decoder;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic                   mclk_in = 1'b0;
	logic                   resetn_in = 1'b0;
	wire logic              cmd_a;
	wire logic              cmd_b;
	mcd_pkg::mcd_mode_t     mode = mcd_pkg::MCD_MODE_OFF;
	mcd_pkg::mcd_pwm_fmt_t  fmt = mcd_pkg::MCD_PWM_ONE;
	logic                   inv = 1'b0;
	logic                   prot = 1'b0;
	logic [15:0]            scale = 16'h1000;
	mcd_pkg::mcd_step_fmt_t sfmt = mcd_pkg::MCD_STEP_DIR;
	logic                   sinv = 1'b0;
	logic                   fall = 1'b0;
	logic signed [15:0]     gear = 16'h0001;
	logic [15:0]            accel = 16'h0000;
	logic [15:0]            vmax = 16'h0100;
	logic signed [15:0]     cur_cmd;
	logic signed [15:0]     vel_cmd;
	logic signed [31:0]     pos_cmd;
	logic signed [31:0]     pos_tgt;
	logic                   stuck;
	logic signed [31:0]     exp_pos = 32'h0;
	int                     errors = 0;
	int                     compares = 0;
	int                     cyc = 0;
	int                     k;
	int                     s;
	logic                   pol;
	logic [1:0]             quad [4] = '{2'h2, 2'h3, 2'h1, 2'h0};

	always #10 mclk_in = ~mclk_in;

	mcd_ctl_model mcd_ctl_model_inst (.clk_in(mclk_in), .a_out(cmd_a), .b_out(cmd_b));

	mcd_cmd_decoder #(.STUCK_CYC(200)) mcd_cmd_decoder_inst (
		.mclk_in(mclk_in), .resetn_in(resetn_in), .cmd_a_in(cmd_a), .cmd_b_in(cmd_b),
		.mode_in(mode), .pwm_fmt_in(fmt), .pwm_invert_in(inv), .pwm_protect_in(prot),
		.pwm_scale_in(scale), .step_fmt_in(sfmt), .step_invert_in(sinv),
		.step_fall_edge_in(fall), .gear_in(gear), .max_accel_in(accel),
		.max_vel_in(vmax), .cur_cmd_out(cur_cmd), .vel_cmd_out(vel_cmd),
		.pos_cmd_out(pos_cmd), .pos_target_out(pos_tgt), .pwm_stuck_out(stuck));

	// ****************************************
	// Expectations
	// ****************************************
	// Signed duty value before scaling, 4096 stands for full duty
	function automatic int exp_v(input logic f, input logic i, input logic p, input int d);
		int v;
		if (f) begin
			v = i ? 4096 - d : d;
			v = p ? v : -v;
		end else begin
			v = (d - 2048) * 2;
			v = i ? -v : v;
		end
		return v;
	endfunction

	// Scaled and clamped command
	function automatic logic signed [15:0] exp_cmd(input int v, input int sc);
		int r;
		r = (v * sc) >>> 12;
		r = (r > 32767) ? 32767 : ((r < -32767) ? -32767 : r);
		return 16'(r);
	endfunction

	// Only the output of the selected mode carries the command
	task automatic check_cmd(input logic signed [15:0] c);
		`CHK("cur_cmd", (mode == mcd_pkg::MCD_MODE_CUR) ? c : 16'sh0, cur_cmd)
		`CHK("vel_cmd", (mode == mcd_pkg::MCD_MODE_VEL) ? c : 16'sh0, vel_cmd)
	endtask

	// One pulse on A or B; mid-pulse check tells which edge counted
	task automatic pulse(input logic on_b, input logic lvl, input int dlt);
		logic signed [31:0] nxt;
		nxt = exp_pos + 32'(dlt);
		if (on_b) mcd_ctl_model_inst.drive(lvl, 1'b1);
		else mcd_ctl_model_inst.drive(1'b1, lvl);
		`CHK("tgt_mid", fall ? exp_pos : nxt, pos_tgt)
		if (on_b) mcd_ctl_model_inst.drive(lvl, 1'b0);
		else mcd_ctl_model_inst.drive(1'b0, lvl);
		exp_pos = nxt;
		`CHK("tgt_end", exp_pos, pos_tgt)
		`CHK("pos_cmd", exp_pos, pos_cmd)
	endtask

	// Verdict in one place
	task automatic finish_test();
		$display("checks %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// Cut a hang short; the run needs well under this
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			finish_test();
		end
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		void'($urandom(76));
		repeat (3) @(negedge mclk_in);
		`CHK("rst_pos", 32'sh0, pos_tgt)
		resetn_in = 1'b1;
		// Random PWM; the first is one-wire half duty, the second only fixes scale and inversion
		for (int i = 0; i < 8; i++) begin
			@(negedge mclk_in);
			mode = ($urandom % 2) ? mcd_pkg::MCD_MODE_VEL : mcd_pkg::MCD_MODE_CUR;
			fmt = (i == 0) ? mcd_pkg::MCD_PWM_ONE : mcd_pkg::mcd_pwm_fmt_t'($urandom % 2);
			inv = (i < 2) ? 1'b0 : 1'($urandom);
			scale = (i < 2) ? 16'h1000 : 16'($urandom);
			k = (i == 0) ? 32 : 1 + $urandom % 63;
			pol = 1'($urandom);
			mcd_ctl_model_inst.pwm(k, 64, 5, pol);
			check_cmd(exp_cmd(exp_v(fmt, inv, pol, k * 64), scale));
			`CHK("stuck", 1'b0, stuck)
		end
		// Pin held high: full duty, or zero when protected
		for (int i = 0; i < 4; i++) begin
			@(negedge mclk_in);
			prot = i[1];
			fmt = mcd_pkg::mcd_pwm_fmt_t'(i[0]);
			inv = 1'b0;
			scale = 16'h1000;
			mode = mcd_pkg::MCD_MODE_CUR;
			mcd_ctl_model_inst.drive(1'b0, 1'b1);
			mcd_ctl_model_inst.drive(1'b1, 1'b1);
			repeat (300) @(negedge mclk_in);
			check_cmd(prot ? 16'sh0 : exp_cmd(exp_v(fmt, 1'b0, 1'b1, 4096), 4096));
			`CHK("stuck", 1'b1, stuck)
		end
		// Steps are refused outside position mode
		mcd_ctl_model_inst.drive(1'b0, 1'b1);
		pulse(1'b0, 1'b1, 0);
		mode = mcd_pkg::MCD_MODE_POS;
		// Step with direction, every mix of sign, edge and inversion
		for (int i = 0; i < 8; i++) begin
			@(negedge mclk_in);
			{pol, fall, sinv} = 3'(i);
			gear = 16'($urandom % 500) - 16'sd250;
			mcd_ctl_model_inst.drive(1'b0, pol);
			pulse(1'b0, pol, (pol ^ sinv) ? int'(gear) : -int'(gear));
		end
		// Up and down pulses
		sfmt = mcd_pkg::MCD_STEP_UPDN;
		for (int i = 0; i < 4; i++) begin
			@(negedge mclk_in);
			{fall, sinv} = 2'(i);
			s = sinv ? -int'(gear) : int'(gear);
			pulse(1'b0, 1'b0, s);
			pulse(1'b1, 1'b0, -s);
		end
		// Quadrature forward then backward, both senses
		sfmt = mcd_pkg::MCD_STEP_QUAD;
		for (int i = 0; i < 4; i++) begin
			{pol, sinv} = 2'(i);
			gear = 16'($urandom % 100) + 16'sd1;
			s = (sinv ^ pol) ? -int'(gear) : int'(gear);
			for (int j = 0; j < 4; j++) begin
				k = pol ? (6 - j) % 4 : j;
				mcd_ctl_model_inst.drive(quad[k][1], quad[k][0]);
				exp_pos = exp_pos + 32'(s);
				`CHK("quad_tgt", exp_pos, pos_tgt)
			end
			`CHK("quad_pos", exp_pos, pos_cmd)
		end
		// Limited acceleration lags a large step, zero limit snaps to it
		sfmt = mcd_pkg::MCD_STEP_DIR;
		{sinv, fall} = 2'b00;
		gear = 16'sd1000;
		accel = 16'h0001;
		mcd_ctl_model_inst.drive(1'b0, 1'b1);
		mcd_ctl_model_inst.drive(1'b1, 1'b1);
		repeat (60) @(negedge mclk_in);
		`CHK("traj_lag", 1'b1, pos_cmd !== pos_tgt)
		accel = 16'h0000;
		mcd_ctl_model_inst.drive(1'b0, 1'b1);
		exp_pos = exp_pos + 32'sd1000;
		`CHK("traj_off", exp_pos, pos_cmd)
		finish_test();
	end
endmodule

`default_nettype wire
